/* logic/pitu_pkg.sv */
`default_nettype none
package pitu_pkg;
    localparam int NUM_TIMERS = 8;
    localparam int TIDX_W = 3;
    localparam int AXI_AW = 12;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAST_TICK_NS = 10_000_000;
    localparam int SLOW_TICK_NS = 100_000_000;
    localparam int FAST_TICK_CYCLES = FAST_TICK_NS / CLK_PERIOD_NS;
    localparam int SLOW_PER_FAST = SLOW_TICK_NS / FAST_TICK_NS;
    localparam int SLOW_CNT_W = 4;
    // Caps in ticks: 999.9 s at 0.1 s, 99.99 s at 0.01 s, both 9999
    localparam logic [31:0] SINGLE_MAX = 32'h0000270f;
    // 9999999.9 s and 999999.99 s both give 99999999 ticks
    localparam logic [31:0] ACCUM_MAX = 32'h05f5e0ff;
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [AXI_AW-1:0] ADDR_MODE = 12'h004;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 12'h008;
    localparam logic [AXI_AW-1:0] ADDR_IRQ_STATUS = 12'h00c;
    localparam logic [AXI_AW-1:0] ADDR_IRQ_MASK = 12'h010;
    localparam logic [AXI_AW-1:0] ADDR_VALUE_BASE = 12'h100;
    localparam logic [AXI_AW-1:0] ADDR_PRESET_BASE = 12'h200;
    localparam logic [AXI_AW-1:0] WINDOW_MASK = 12'h01f;
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_CLR_LSB = 8;
    localparam int MODE_W = 2;
    localparam logic [31:0] PRESET_RESET = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [MODE_W-1:0] {
        MODE_SINGLE,
        MODE_SINGLE_FAST,
        MODE_ACCUM,
        MODE_ACCUM_FAST
    } pitu_mode_t;
    typedef struct packed {
        logic run;
        logic clr;
        pitu_mode_t mode;
    } pitu_tmr_ctl_t;
    typedef struct packed {
        logic tick_fast;
        logic tick_slow;
    } pitu_tick_t;
endpackage : pitu_pkg
`default_nettype wire

/* logic/pitu_tick_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module pitu_tick_gen
    import pitu_pkg::*;
#(
    parameter int FAST_CYCLES = FAST_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    output pitu_tick_t tick
);
    logic [31:0] cnt;
    logic [SLOW_CNT_W-1:0] slow_cnt;

    // Slow tick always lands on a fast tick, so both kinds step together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            slow_cnt <= '0;
            tick <= '0;
        end else if (cnt == 32'(FAST_CYCLES - 1)) begin
            cnt <= '0;
            tick.tick_fast <= 1'b1;
            if (slow_cnt == SLOW_CNT_W'(SLOW_PER_FAST - 1)) begin
                slow_cnt <= '0;
                tick.tick_slow <= 1'b1;
            end else begin
                slow_cnt <= slow_cnt + 1'b1;
                tick.tick_slow <= 1'b0;
            end
        end else begin
            cnt <= cnt + 32'h00000001;
            tick <= '0;
        end
    end
endmodule : pitu_tick_gen
`default_nettype wire

/* logic/pitu_timer_bank.sv */
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pitu_timer_bank
    import pitu_pkg::*;
#(
    parameter int FAST_TICK_CYCLES_P = FAST_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    pitu_tick_t tick;
    pitu_tmr_ctl_t ctl [NUM_TIMERS];
    logic [31:0] value [NUM_TIMERS];
    logic [31:0] preset [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] tmr_run;
    logic [NUM_TIMERS-1:0] tmr_clr;
    logic [MODE_W*NUM_TIMERS-1:0] mode_reg;
    logic [NUM_TIMERS-1:0] status;
    logic [NUM_TIMERS-1:0] status_q;
    logic [NUM_TIMERS-1:0] irq_pend;
    logic [NUM_TIMERS-1:0] irq_mask;
    logic aw_held;
    logic w_held;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic ar_take;
    logic rd_clear_irq;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] next_ctrl;
    logic [31:0] next_mode;
    logic [31:0] next_mask;

    function automatic logic in_window(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] base);
        in_window = (a & ~WINDOW_MASK) == base;
    endfunction : in_window

    function automatic logic [TIDX_W-1:0] win_idx(input logic [AXI_AW-1:0] a);
        win_idx = a[TIDX_W+1:2];
    endfunction : win_idx

    function automatic logic [AXI_AW-1:0] word_of(input logic [AXI_AW-1:0] a);
        word_of = {a[AXI_AW-1:2], 2'h0};
    endfunction : word_of

    function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
        logic [AXI_AW-1:0] w;
        w = word_of(a);
        addr_ok = (w == ADDR_CTRL) || (w == ADDR_MODE) || (w == ADDR_STATUS) ||
                  (w == ADDR_IRQ_STATUS) || (w == ADDR_IRQ_MASK) ||
                  in_window(w, ADDR_VALUE_BASE) || in_window(w, ADDR_PRESET_BASE);
    endfunction : addr_ok

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = r;
    endfunction : merge

    function automatic logic is_accum(input pitu_mode_t m);
        is_accum = (m == MODE_ACCUM) || (m == MODE_ACCUM_FAST);
    endfunction : is_accum

    function automatic logic [31:0] cap_of(input pitu_mode_t m);
        unique case (m)
            MODE_SINGLE: cap_of = SINGLE_MAX;
            MODE_SINGLE_FAST: cap_of = SINGLE_MAX;
            MODE_ACCUM: cap_of = ACCUM_MAX;
            MODE_ACCUM_FAST: cap_of = ACCUM_MAX;
        endcase
    endfunction : cap_of

    function automatic logic tick_of(input pitu_mode_t m, input pitu_tick_t t);
        unique case (m)
            MODE_SINGLE: tick_of = t.tick_slow;
            MODE_SINGLE_FAST: tick_of = t.tick_fast;
            MODE_ACCUM: tick_of = t.tick_slow;
            MODE_ACCUM_FAST: tick_of = t.tick_fast;
        endcase
    endfunction : tick_of

    pitu_tick_gen #(
        .FAST_CYCLES(FAST_TICK_CYCLES_P)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_clear_irq = ar_take && (word_of(s_axi_araddr) == ADDR_IRQ_STATUS);
    assign next_ctrl = merge({16'h0000, tmr_clr, tmr_run}, wr_data, wr_strb);
    assign next_mode = merge({16'h0000, mode_reg}, wr_data, wr_strb);
    assign next_mask = merge({24'h000000, irq_mask}, wr_data, wr_strb);

    // Address and data are taken independently, either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            wr_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software drives the timer inputs through this word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmr_run <= '0;
            tmr_clr <= '0;
        end else if (do_write && word_of(wr_addr) == ADDR_CTRL) begin
            {tmr_clr, tmr_run} <= next_ctrl[CTRL_CLR_LSB+NUM_TIMERS-1:CTRL_RUN_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= '0;
        end else if (do_write && word_of(wr_addr) == ADDR_MODE) begin
            mode_reg <= next_mode[MODE_W*NUM_TIMERS-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (do_write && word_of(wr_addr) == ADDR_IRQ_MASK) begin
            irq_mask <= next_mask[NUM_TIMERS-1:0];
        end
    end

    // Preset range is the writer's business; any 32-bit value is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                preset[i] <= PRESET_RESET;
            end
        end else if (do_write && in_window(wr_addr, ADDR_PRESET_BASE)) begin
            preset[win_idx(wr_addr)] <= merge(preset[win_idx(wr_addr)], wr_data, wr_strb);
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        rd_ok = addr_ok(s_axi_araddr);
        if (word_of(s_axi_araddr) == ADDR_CTRL) begin
            rd_data = {16'h0000, tmr_clr, tmr_run};
        end else if (word_of(s_axi_araddr) == ADDR_MODE) begin
            rd_data = {16'h0000, mode_reg};
        end else if (word_of(s_axi_araddr) == ADDR_STATUS) begin
            rd_data = {24'h000000, status};
        end else if (word_of(s_axi_araddr) == ADDR_IRQ_STATUS) begin
            rd_data = {24'h000000, irq_pend};
        end else if (word_of(s_axi_araddr) == ADDR_IRQ_MASK) begin
            rd_data = {24'h000000, irq_mask};
        end else if (in_window(s_axi_araddr, ADDR_VALUE_BASE)) begin
            rd_data = value[win_idx(s_axi_araddr)];
        end else if (in_window(s_axi_araddr, ADDR_PRESET_BASE)) begin
            rd_data = preset[win_idx(s_axi_araddr)];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
        assign ctl[i] = '{run: tmr_run[i], clr: tmr_clr[i], mode: pitu_mode_t'(mode_reg[MODE_W*i +: MODE_W])};
        assign status[i] = value[i] >= preset[i];

        // Counting waits for the shared tick, clearing does not
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                value[i] <= '0;
            end else if (is_accum(ctl[i].mode)) begin
                if (ctl[i].clr) begin
                    value[i] <= '0;
                end else if (ctl[i].run && tick_of(ctl[i].mode, tick) &&
                             value[i] < cap_of(ctl[i].mode)) begin
                    value[i] <= value[i] + 32'h00000001;
                end
            end else begin
                if (!ctl[i].run) begin
                    value[i] <= '0;
                end else if (tick_of(ctl[i].mode, tick) &&
                             value[i] < cap_of(ctl[i].mode)) begin
                    value[i] <= value[i] + 32'h00000001;
                end
            end
        end

        property p_single_clear;
            @(posedge aclk) disable iff (!aresetn)
            (!is_accum(ctl[i].mode) && !ctl[i].run) |=> (value[i] == 32'h00000000);
        endproperty
        a_single_clear: assert property (p_single_clear) else $error("single timer not cleared");

        property p_slow_step;
            @(posedge aclk) disable iff (!aresetn)
            (ctl[i].mode == MODE_SINGLE && ctl[i].run && tick.tick_slow && value[i] < SINGLE_MAX)
            ##1 (ctl[i].mode == MODE_SINGLE && ctl[i].run) |-> value[i] == $past(value[i]) + 32'h00000001;
        endproperty
        a_slow_step: assert property (p_slow_step) else $error("slow timer missed a step");

        property p_fast_cap;
            @(posedge aclk) disable iff (!aresetn)
            (ctl[i].mode == MODE_SINGLE_FAST && ctl[i].run && value[i] == SINGLE_MAX)
            ##1 (ctl[i].mode == MODE_SINGLE_FAST && ctl[i].run) |-> value[i] == SINGLE_MAX;
        endproperty
        a_fast_cap: assert property (p_fast_cap) else $error("fast timer passed its ceiling");

        property p_status_irq;
            @(posedge aclk) disable iff (!aresetn)
            $rose(status[i]) |=> irq_pend[i];
        endproperty
        a_status_irq: assert property (p_status_irq) else $error("status rise not flagged");

        property p_accum_hold;
            @(posedge aclk) disable iff (!aresetn)
            (is_accum(ctl[i].mode) && !ctl[i].run && !ctl[i].clr) [*2] |-> $stable(value[i]);
        endproperty
        a_accum_hold: assert property (p_accum_hold) else $error("stopped timer lost its value");

        property p_accum_clr;
            @(posedge aclk) disable iff (!aresetn)
            (is_accum(ctl[i].mode) && ctl[i].clr) |=> (value[i] == 32'h00000000);
        endproperty
        a_accum_clr: assert property (p_accum_clr) else $error("accumulating reset ignored");

        property p_accum_cap;
            @(posedge aclk) disable iff (!aresetn)
            is_accum(ctl[i].mode) |-> value[i] <= ACCUM_MAX;
        endproperty
        a_accum_cap: assert property (p_accum_cap) else $error("accumulating value over ceiling");

        property p_tick_only;
            @(posedge aclk) disable iff (!aresetn)
            (!tick.tick_fast && ctl[i].run && !ctl[i].clr) ##1 (ctl[i].run && !ctl[i].clr)
            |-> $stable(value[i]);
        endproperty
        a_tick_only: assert property (p_tick_only) else $error("value moved without a tick");
    end

    // Set wins over a read clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '1;
            irq_pend <= '0;
            irq <= 1'b0;
        end else begin
            status_q <= status;
            irq_pend <= (irq_pend & ~{NUM_TIMERS{rd_clear_irq}}) | (status & ~status_q);
            irq <= |(irq_pend & irq_mask);
        end
    end

    property p_value_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_take && in_window(s_axi_araddr, ADDR_VALUE_BASE))
        |=> s_axi_rvalid && s_axi_rdata == $past(value[win_idx(s_axi_araddr)]);
    endproperty
    a_value_read: assert property (p_value_read) else $error("value read returned wrong word");

    property p_status_read;
        @(posedge aclk) disable iff (!aresetn)
        (ar_take && word_of(s_axi_araddr) == ADDR_STATUS)
        |=> s_axi_rdata == {24'h000000, $past(status)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("packed status read wrong");

    property p_irq_level;
        @(posedge aclk) disable iff (!aresetn)
        (|(irq_pend & irq_mask)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule : pitu_timer_bank
`default_nettype wire

/* sim/test_plc_interval_timer_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module test_plc_interval_timer_unit import pitu_pkg::*;;
    // Short prescale keeps the fast single cap reachable in a short run
    localparam int FTC = 2;
    localparam int SLOW_C = FTC * SLOW_PER_FAST;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_AW-1:0] awaddr = '0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [AXI_AW-1:0] araddr = '0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v, a2, a3;
    logic [1:0] r;
    logic [31:0] pre [4];
    logic [3:0] strb_sel = 4'hf;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int t_mark = 0;
    int t0, el, w;
    integer seed = 74678;

    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    pitu_timer_bank #(.FAST_TICK_CYCLES_P(FTC)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq(irq));

    function automatic logic [31:0] exp_ticks(input int cycles, input int per);
        return 32'(cycles / per);
    endfunction : exp_ticks

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    // Tick phase and read latency blur the count by a couple of ticks
    task automatic check_near(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if ((got + 32'h2 >= exp && got <= exp + 32'h1) !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected about %0d seen %0d", name, exp, got);
        end
    endtask : check_near

    task automatic axi_write(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        rs = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb_sel;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
                t_mark = cyc;
            end
        end
        check_val("write done", 32'h1, {31'h0, done});
    endtask : axi_write

    task automatic axi_read(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        rs = 2'h3;
        d = '1;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        check_val("read done", 32'h1, {31'h0, done});
    endtask : axi_read

    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
        logic [1:0] rs;
        axi_write(a, d, rs);
        check_val("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask : wr

    task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d);
        logic [1:0] rs;
        axi_read(a, d, rs);
        check_val("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask : rd

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #500_000;
        n_mismatch++;
        $display("CHECK FAILED watchdog expected end seen timeout");
        finish_test();
    end

    initial begin
        logic [AXI_AW-1:0] rst_addr [6];
        rst_addr = '{ADDR_CTRL, ADDR_MODE, ADDR_IRQ_MASK, ADDR_IRQ_STATUS, ADDR_VALUE_BASE, ADDR_PRESET_BASE};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_addr[i]) begin
            rd(rst_addr[i], v);
            check_val("reset value", 32'h0, v);
        end
        rd(ADDR_STATUS, v);
        check_val("status after reset", 32'h000000ff, v);
        axi_read(12'h040, v, r);
        check_val("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        check_val("unmapped rdata", 32'h0, v);
        axi_write(12'h044, 32'hffffffff, r);
        check_val("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        for (int i = 0; i < 4; i++) begin
            pre[i] = 32'h1 + ($unsigned($random(seed)) % 8);
            wr(ADDR_PRESET_BASE + 12'(4 * i), pre[i]);
        end
        // Timers 0..3: single, single fast, accumulating, accumulating fast
        wr(ADDR_MODE, 32'h000000e4);
        wr(ADDR_CTRL, 32'h0000000f);
        t0 = t_mark;
        w = 600 + ($unsigned($random(seed)) % 400);
        repeat (w) @(posedge aclk);
        rd(ADDR_VALUE_BASE, v);
        check_near("single value", exp_ticks(cyc - t0, SLOW_C), v);
        rd(ADDR_VALUE_BASE + 12'h004, v);
        check_near("fast single value", exp_ticks(cyc - t0, FTC), v);
        wr(ADDR_CTRL, 32'h0);
        el = t_mark - t0;
        rd(ADDR_VALUE_BASE, v);
        check_val("single after drop", 32'h0, v);
        rd(ADDR_VALUE_BASE + 12'h004, v);
        check_val("fast single after drop", 32'h0, v);
        rd(ADDR_VALUE_BASE + 12'h008, a2);
        check_near("accum value", exp_ticks(el, SLOW_C), a2);
        rd(ADDR_VALUE_BASE + 12'h00c, a3);
        check_near("fast accum value", exp_ticks(el, FTC), a3);
        rd(ADDR_STATUS, v);
        check_val("status", {28'h000000f, a3 >= pre[3], a2 >= pre[2], 2'b00}, v);
        wr(ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        check_val("irq masked", 32'h0, {31'h0, irq});
        wr(ADDR_IRQ_MASK, 32'h4);
        repeat (2) @(posedge aclk);
        check_val("irq unmasked", 32'h1, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, v);
        check_val("irq status", 32'h0000000f, v);
        repeat (2) @(posedge aclk);
        check_val("irq after clear", 32'h0, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, v);
        check_val("irq status cleared", 32'h0, v);
        repeat (w) @(posedge aclk);
        rd(ADDR_VALUE_BASE + 12'h008, v);
        check_val("accum held", a2, v);
        wr(ADDR_CTRL, 32'h0000000c);
        t0 = t_mark;
        repeat (200) @(posedge aclk);
        wr(ADDR_CTRL, 32'h0);
        el = t_mark - t0;
        rd(ADDR_VALUE_BASE + 12'h008, v);
        check_near("accum resumed", a2 + exp_ticks(el, SLOW_C), v);
        rd(ADDR_VALUE_BASE + 12'h00c, v);
        check_near("fast accum resumed", a3 + exp_ticks(el, FTC), v);
        // Reset input wins over a running start input
        wr(ADDR_CTRL, 32'h00000c0c);
        repeat (50) @(posedge aclk);
        rd(ADDR_VALUE_BASE + 12'h008, v);
        check_val("accum cleared", 32'h0, v);
        rd(ADDR_VALUE_BASE + 12'h00c, v);
        check_val("fast accum cleared", 32'h0, v);
        wr(ADDR_CTRL, 32'h0000000c);
        t0 = t_mark;
        repeat (100) @(posedge aclk);
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_VALUE_BASE + 12'h00c, v);
        check_near("fast accum from zero", exp_ticks(t_mark - t0, FTC), v);
        wr(ADDR_CTRL, 32'h00000003);
        t0 = t_mark;
        repeat (20100) @(posedge aclk);
        rd(ADDR_VALUE_BASE + 12'h004, v);
        check_val("fast single cap", SINGLE_MAX, v);
        rd(ADDR_VALUE_BASE, v);
        check_near("single long run", exp_ticks(cyc - t0, SLOW_C), v);
        wr(ADDR_CTRL, 32'h0);
        // Only byte 1 may land; the rest keeps its reset value
        v = $random(seed);
        strb_sel = 4'h2;
        wr(ADDR_PRESET_BASE + 12'h010, v);
        strb_sel = 4'hf;
        rd(ADDR_PRESET_BASE + 12'h010, a2);
        check_val("byte strobe preset", {16'h0000, v[15:8], 8'h00}, a2);
        finish_test();
    end
endmodule : test_plc_interval_timer_unit
`default_nettype wire
